// ==== rtl/fsp_defs.svh ====
// Offsets, field positions, reset values and codes of the flash sector protection block.
`ifndef FSP_DEFS_SVH
`define FSP_DEFS_SVH

// Register byte offsets on the register bus.
`define FSP_ADR_PROT 8'h00
`define FSP_ADR_STAT 8'h04
`define FSP_ADR_MASK 8'h08
`define FSP_ADR_CMD 8'h0C

// Protection register fields.
`define FSP_UP_MSB 7
`define FSP_UP_LSB 3
`define FSP_LOW_MSB 2
`define FSP_LOW_LSB 0
`define FSP_PROT_RST 8'hFF

// Upper range codes.
`define FSP_UP_NONE 5'h1F

// Lower range codes.
`define FSP_LOW_FULL 3'h0
`define FSP_LOW_RSV1 3'h1
`define FSP_LOW_RSV2 3'h2
`define FSP_LOW_4K 3'h3
`define FSP_LOW_3K 3'h4
`define FSP_LOW_2K 3'h5
`define FSP_LOW_1K 3'h6
`define FSP_LOW_NONE 3'h7

// Array size in kbytes.
`define FSP_ARRAY_KB 6'h20

// Status and mask bit positions.
`define FSP_ST_VIOL 0
`define FSP_ST_MASS 1
`define FSP_ST_DONE 2
`define FSP_ST_REFUSED 3
`define FSP_ST_W 4

// Command register fields.
`define FSP_CMD_ADR_MSB 14
`define FSP_CMD_KIND_MSB 17
`define FSP_CMD_KIND_LSB 16

`endif

// ==== rtl/fsp_pkg.sv ====
// Types shared by the flash sector protection design.
package fsp_pkg;

  // Flash operations that the command register can request.
  typedef enum logic [1:0] {
    FSP_PROG,
    FSP_SECT_ERASE,
    FSP_MASS_ERASE,
    FSP_NOP
  } fsp_cmd_t;

  typedef logic [7:0] fsp_prot_t;

endpackage

// ==== rtl/fsp_range_dec.sv ====
// Decodes a protection byte into an address hit and a protected size.
`timescale 1ns/10ps
`include "fsp_defs.svh"
module fsp_range_dec (
  input wire fsp_pkg::fsp_prot_t prot_val,
  input wire logic [14:0] addr,
  output logic hit,
  output logic [5:0] total_kb
);
  import fsp_pkg::*;

  logic [4:0] up_code;
  logic [2:0] low_code;
  logic [5:0] up_kb;
  logic [5:0] low_kb;
  logic [6:0] sum_kb;

  // Upper range size and lower range size in kbytes.
  always_comb begin
    up_code = prot_val[`FSP_UP_MSB:`FSP_UP_LSB];
    low_code = prot_val[`FSP_LOW_MSB:`FSP_LOW_LSB];
    if (up_code == `FSP_UP_NONE) begin
      up_kb = 6'h00;
    end else begin
      up_kb = 6'h1F - {1'b0, up_code};
    end
    case (low_code)
      `FSP_LOW_4K: low_kb = 6'h04;
      `FSP_LOW_3K: low_kb = 6'h03;
      `FSP_LOW_2K: low_kb = 6'h02;
      `FSP_LOW_1K: low_kb = 6'h01;
      `FSP_LOW_NONE: low_kb = 6'h00;
      default: low_kb = `FSP_ARRAY_KB;
    endcase
  end

  // Overlapping ranges never count above the array size.
  always_comb begin
    sum_kb = {1'b0, up_kb} + {1'b0, low_kb};
    if (sum_kb > {1'b0, `FSP_ARRAY_KB}) begin
      total_kb = `FSP_ARRAY_KB;
    end else begin
      total_kb = sum_kb[5:0];
    end
  end

  // A kbyte sector is hit when it lies in either protected range.
  always_comb begin
    hit = 1'b0;
    if ((up_code != `FSP_UP_NONE) && (addr[14:10] > up_code)) begin
      hit = 1'b1;
    end
    if ({1'b0, addr[14:10]} < low_kb) begin
      hit = 1'b1;
    end
  end

endmodule

// ==== rtl/fsp_top.sv ====
// Flash sector protection register, range checks and command gate.
//
// Functional notes
// - Normal mode accepts protection writes that enlarge the protected area.
// - Normal mode drops writes that would shrink the protected area.
// - Special mode writes the protection register freely.
// - Reset sequence loads the stored protection byte into the register.
// - Program or erase into protected space is rejected and sets the violation flag.
// - Mass erase is refused while any sector is protected.
// - Upper size field sits in bits 7:3, lower size field in 2:0.
// - Upper code n protects the (31-n) kbytes above sector n; 0x1F protects nothing.
// - Lower code protects from base: whole array, 4, 3, 2, 1 kbyte, none.
// - Reserved lower codes written over the bus are stored as the full-array code.
// - Violation flag clears on write of one; while set, commands are refused.
`timescale 1ns/10ps
`include "fsp_defs.svh"
module fsp_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic special_mode_pin,
  input wire fsp_pkg::fsp_prot_t cfg_prot_byte,
  output logic cmd_start_o,
  output fsp_pkg::fsp_cmd_t cmd_kind_o,
  output logic [14:0] cmd_addr_o,
  output logic any_protected_o,
  output logic irq_o
);
  import fsp_pkg::*;

  // Register state.
  fsp_prot_t prot_reg;
  logic [`FSP_ST_W-1:0] stat_reg;
  logic [`FSP_ST_W-1:0] mask_reg;
  logic load_pend_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic start_reg;
  fsp_cmd_t kind_reg;
  logic [14:0] addr_reg;
  logic anyp_reg;
  logic irq_reg;

  // Mode pin synchroniser.
  logic mode_s1_reg;
  logic mode_s2_reg;
  logic mode_s3_reg;
  logic special_reg;

  // Bus decode terms.
  logic bus_req;
  logic wr_en;
  logic rd_en;
  logic hit_prot;
  logic hit_stat;
  logic hit_mask;
  logic hit_cmd;
  logic prot_wr;
  logic stat_wr;
  logic mask_wr;
  logic cmd_lanes_ok;

  // Protection write evaluation.
  fsp_prot_t prot_wr_val;
  fsp_prot_t prot_next;
  logic [5:0] cur_kb;
  logic [5:0] new_kb;
  logic prot_wr_ok;

  // Command evaluation.
  fsp_cmd_t cmd_kind;
  logic [14:0] cmd_addr;
  logic cmd_wr;
  logic cmd_addr_hit;
  logic cmd_viol;
  logic cmd_mass_ref;
  logic cmd_go;
  logic cmd_blocked;
  logic [`FSP_ST_W-1:0] stat_set;
  logic [`FSP_ST_W-1:0] stat_clr;
  logic [`FSP_ST_W-1:0] stat_next;

  // Three flip-flop synchroniser; the mode changes when the last two agree.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_s1_reg <= 1'b0;
      mode_s2_reg <= 1'b0;
      mode_s3_reg <= 1'b0;
    end else begin
      mode_s1_reg <= special_mode_pin;
      mode_s2_reg <= mode_s1_reg;
      mode_s3_reg <= mode_s2_reg;
    end
  end

  // Held mode level, normal mode out of reset.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      special_reg <= 1'b0;
    end else if (mode_s2_reg == mode_s3_reg) begin
      special_reg <= mode_s3_reg;
    end
  end

  // A request is served once, and never while the reset load is pending.
  // Gating on ack keeps a held request from being served a second time.
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_reg && !load_pend_reg;
  assign wr_en = bus_req && wb_we_i;
  assign rd_en = bus_req && !wb_we_i;

  // Address decode.
  always_comb begin
    hit_prot = 1'b0;
    hit_stat = 1'b0;
    hit_mask = 1'b0;
    hit_cmd = 1'b0;
    if (wb_adr_i == `FSP_ADR_PROT) begin
      hit_prot = 1'b1;
    end else if (wb_adr_i == `FSP_ADR_STAT) begin
      hit_stat = 1'b1;
    end else if (wb_adr_i == `FSP_ADR_MASK) begin
      hit_mask = 1'b1;
    end else if (wb_adr_i == `FSP_ADR_CMD) begin
      hit_cmd = 1'b1;
    end
  end

  // Byte-lane qualified register writes; a command must cover all three
  // low lanes so that its kind and its offset always arrive together.
  assign prot_wr = wr_en && hit_prot && wb_sel_i[0];
  assign stat_wr = wr_en && hit_stat && wb_sel_i[0];
  assign mask_wr = wr_en && hit_mask && wb_sel_i[0];
  assign cmd_lanes_ok = (wb_sel_i[2:0] == 3'h7);

  // Reserved lower codes are folded into the full-array code on entry.
  always_comb begin
    prot_wr_val = wb_dat_i[7:0];
    if ((wb_dat_i[`FSP_LOW_MSB:`FSP_LOW_LSB] == `FSP_LOW_RSV1) ||
        (wb_dat_i[`FSP_LOW_MSB:`FSP_LOW_LSB] == `FSP_LOW_RSV2)) begin
      prot_wr_val[`FSP_LOW_MSB:`FSP_LOW_LSB] = `FSP_LOW_FULL;
    end
  end

  // Size of the protection now in force, and the address check for commands.
  fsp_range_dec u_cur_dec (
    .prot_val(prot_reg),
    .addr(cmd_addr),
    .hit(cmd_addr_hit),
    .total_kb(cur_kb)
  );

  // Size of the protection that a write would set.
  fsp_range_dec u_new_dec (
    .prot_val(prot_wr_val),
    .addr(15'h0000),
    .hit(),
    .total_kb(new_kb)
  );

  // Special mode takes any value; normal mode refuses a smaller area.
  always_comb begin
    if (special_reg) begin
      prot_wr_ok = 1'b1;
    end else begin
      prot_wr_ok = (new_kb >= cur_kb);
    end
  end

  // Next protection value from a bus write.
  always_comb begin
    prot_next = prot_reg;
    if (prot_wr && prot_wr_ok) begin
      prot_next = prot_wr_val;
    end
  end

  // Protection register: safe value in reset, then the stored byte.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prot_reg <= `FSP_PROT_RST;
    end else if (load_pend_reg) begin
      prot_reg <= cfg_prot_byte;
    end else begin
      prot_reg <= prot_next;
    end
  end

  // Marks the first cycle after reset release, when the stored byte is copied.
  // Bus requests wait that cycle so software never sees the safe reset value.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      load_pend_reg <= 1'b1;
    end else begin
      load_pend_reg <= 1'b0;
    end
  end

  // Command fields; a command needs the three low byte lanes.
  always_comb begin
    cmd_kind = fsp_cmd_t'(wb_dat_i[`FSP_CMD_KIND_MSB:`FSP_CMD_KIND_LSB]);
    cmd_addr = wb_dat_i[`FSP_CMD_ADR_MSB:0];
    cmd_wr = wr_en && hit_cmd && cmd_lanes_ok && (cmd_kind != FSP_NOP);
  end

  // Command check: blocked flag, protected target, or protected array on mass erase.
  always_comb begin
    cmd_blocked = stat_reg[`FSP_ST_VIOL];
    cmd_viol = 1'b0;
    cmd_mass_ref = 1'b0;
    cmd_go = 1'b0;
    if (cmd_wr && !cmd_blocked) begin
      case (cmd_kind)
        FSP_MASS_ERASE: begin
          if (cur_kb != 6'h00) begin
            cmd_mass_ref = 1'b1;
            cmd_viol = 1'b1;
          end else begin
            cmd_go = 1'b1;
          end
        end
        default: begin
          if (cmd_addr_hit) begin
            cmd_viol = 1'b1;
          end else begin
            cmd_go = 1'b1;
          end
        end
      endcase
    end
  end

  // Status set and clear terms; a set in the same cycle beats the clear.
  always_comb begin
    stat_set = '0;
    stat_set[`FSP_ST_VIOL] = cmd_viol;
    stat_set[`FSP_ST_MASS] = cmd_mass_ref;
    stat_set[`FSP_ST_DONE] = cmd_go;
    stat_set[`FSP_ST_REFUSED] = cmd_wr && cmd_blocked;
    stat_clr = '0;
    if (stat_wr) begin
      stat_clr = wb_dat_i[`FSP_ST_W-1:0];
    end
    stat_next = (stat_reg & ~stat_clr) | stat_set;
  end

  // Sticky status bits.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= stat_next;
    end
  end

  // Interrupt mask, all events masked out of reset.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mask_reg <= '0;
    end else if (mask_wr) begin
      mask_reg <= wb_dat_i[`FSP_ST_W-1:0];
    end
  end

  // Level interrupt, high while an unmasked status bit is set.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(stat_next & mask_reg);
    end
  end

  // Command launch towards the flash sequencer, one cycle wide.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      start_reg <= 1'b0;
      kind_reg <= FSP_NOP;
      addr_reg <= 15'h0000;
    end else begin
      start_reg <= cmd_go;
      if (cmd_go) begin
        kind_reg <= cmd_kind;
        addr_reg <= cmd_addr;
      end
    end
  end

  // Any protection in force, for the flash controller and security logic.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      anyp_reg <= 1'b0;
    end else begin
      anyp_reg <= (cur_kb != 6'h00);
    end
  end

  // Bus acknowledge, one cycle per request.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req;
    end
  end

  // Read data; unmapped offsets and writes return zero.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_en) begin
      rdata_reg <= 32'h0000_0000;
      if (hit_prot) begin
        rdata_reg[7:0] <= prot_reg;
      end else if (hit_stat) begin
        rdata_reg[`FSP_ST_W-1:0] <= stat_reg;
      end else if (hit_mask) begin
        rdata_reg[`FSP_ST_W-1:0] <= mask_reg;
      end else if (hit_cmd) begin
        rdata_reg[`FSP_CMD_ADR_MSB:0] <= addr_reg;
        rdata_reg[`FSP_CMD_KIND_MSB:`FSP_CMD_KIND_LSB] <= kind_reg;
      end
    end else if (!bus_req) begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  // Outputs straight from flip-flops.
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  assign cmd_start_o = start_reg;
  assign cmd_kind_o = kind_reg;
  assign cmd_addr_o = addr_reg;
  assign any_protected_o = anyp_reg;
  assign irq_o = irq_reg;

endmodule

// ==== test/fsp_assertions.sv ====
// Port-level timing checks of the flash sector protection block.
`timescale 1ns/10ps
`include "fsp_defs.svh"
module fsp_assertions (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] wb_adr_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic cmd_start_o,
  input wire fsp_pkg::fsp_cmd_t cmd_kind_o,
  input wire logic [14:0] cmd_addr_o,
  input wire logic any_protected_o,
  input wire logic irq_o
);
  import fsp_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // Bus answers are single pulses tied to a live request.
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ack_req: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i)
    else $error("ack without request");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("data outside ack");
  // Reset leaves outputs quiet and the first cycle unanswered.
  a_reset_quiet: assert property ($fell(rst) |-> !irq_o && !cmd_start_o ##1 !wb_ack_o)
    else $error("outputs busy after reset");
  // A launch is one pulse, caused by a command write.
  a_start_pulse: assert property (cmd_start_o |=> !cmd_start_o)
    else $error("start too long");
  a_start_cause: assert property (cmd_start_o |-> wb_ack_o && wb_we_i && wb_adr_i == `FSP_ADR_CMD)
    else $error("start without command write");
  a_start_real: assert property (cmd_start_o |-> cmd_kind_o != FSP_NOP)
    else $error("empty command launched");
  a_mass_guard: assert property (cmd_start_o && cmd_kind_o == FSP_MASS_ERASE |-> !any_protected_o)
    else $error("mass erase while protected");
  a_cmd_hold: assert property (!cmd_start_o |-> $stable(cmd_kind_o) && $stable(cmd_addr_o))
    else $error("command outputs moved");
  a_irq_cause: assert property ($rose(irq_o) |-> wb_ack_o || $past(wb_ack_o))
    else $error("irq without bus cause");
  c_start: cover property (cmd_start_o);
  c_mass: cover property (cmd_start_o && cmd_kind_o == FSP_MASS_ERASE);
  c_irq: cover property ($rose(irq_o));
endmodule

bind fsp_top fsp_assertions u_chk (.core_clk, .rst, .wb_adr_i, .wb_we_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .wb_dat_o, .cmd_start_o, .cmd_kind_o, .cmd_addr_o, .any_protected_o, .irq_o);

// ==== test/flash_sector_protection_tb_top.sv ====
// Self-checking bench of the flash sector protection block.
`timescale 1ns/10ps
`include "fsp_defs.svh"
module flash_sector_protection_tb_top;
  import fsp_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic [3:0] sel_use = 4'hF;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic smode = 1'b0;
  fsp_prot_t cfg = 8'hFF;
  logic [31:0] rdat;
  logic [31:0] r;
  logic ack, start, anyp, irq, st;
  fsp_cmd_t kind;
  logic [14:0] caddr;
  int fails = 0;
  int tests_run = 0;
  // Free-running 50 MHz clock.
  always #10 core_clk = ~core_clk;
  fsp_top DUT (.core_clk, .rst, .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
    .special_mode_pin(smode), .cfg_prot_byte(cfg), .cmd_start_o(start),
    .cmd_kind_o(kind), .cmd_addr_o(caddr), .any_protected_o(anyp), .irq_o(irq));
  // Protected kbytes of both ranges together, capped at the array size.
  function automatic int kb(input fsp_prot_t p);
    int u;
    int l;
    u = (p[7:3] == 5'h1F) ? 0 : 31 - p[7:3];
    l = (p[2:0] < 3'h3) ? 32 : 7 - p[2:0];
    return (u + l > 32) ? 32 : u + l;
  endfunction
  // Value kept when a byte is written: reserved lower codes become full.
  function automatic fsp_prot_t fix(input fsp_prot_t p);
    return (p[2:0] == 3'h1 || p[2:0] == 3'h2) ? {p[7:3], 3'h0} : p;
  endfunction
  // Status bits a command should leave.
  function automatic logic [3:0] stat(input fsp_prot_t p, input fsp_cmd_t k,
    input logic [14:0] a);
    if (k == FSP_NOP) return 4'h0;
    if (k == FSP_MASS_ERASE) return (kb(p) != 0) ? 4'h3 : 4'h4;
    if ((p[7:3] != 5'h1F && a[14:10] > p[7:3]) || kb({5'h1F, p[2:0]}) > a[14:10]) return 4'h1;
    return 4'h4;
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One classic bus cycle; read data and launch pulse are taken at the ack edge.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    adr <= a;
    dat <= d;
    we <= w;
    sel <= sel_use;
    cyc <= 1'b1;
    stb <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    r = rdat;
    st = start;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) begin
      fails++;
      final_report();
    end
  endtask
  task automatic prot(input fsp_prot_t v, input fsp_prot_t e);
    wb(1'b1, `FSP_ADR_PROT, 32'(v));
    wb(1'b0, `FSP_ADR_PROT, 32'h0);
    check("prot", 32'(e), r);
    check("anyp", 32'(kb(e) != 0), 32'(anyp));
  endtask
  // Issues a command, checks launch, status and irq, then clears status.
  task automatic cmd(input fsp_prot_t p, input fsp_cmd_t k, input logic [14:0] a);
    logic [3:0] e;
    e = stat(p, k, a);
    wb(1'b1, `FSP_ADR_CMD, {14'h0, k, 1'b0, a});
    check("start", 32'(e == 4'h4), 32'(st));
    if (e == 4'h4) check("addr", 32'(a), 32'(caddr));
    if (e == 4'h4) check("kind", 32'(k), 32'(kind));
    wb(1'b0, `FSP_ADR_STAT, 32'h0);
    check("status", 32'(e), r);
    check("irq", 32'(e != 0), 32'(irq));
    wb(1'b1, `FSP_ADR_STAT, 32'hF);
  endtask
  task automatic do_reset(input fsp_prot_t c);
    cfg <= c;
    rst <= 1'b1;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    wb(1'b0, `FSP_ADR_PROT, 32'h0);
    check("reset load", 32'(c), r);
  endtask
  // Main sequence.
  initial begin
    fsp_prot_t p;
    fsp_prot_t v;
    void'($urandom(78));
    p = {5'($urandom), 3'h6};
    do_reset(p);
    $display("test reset done");
    for (int i = 0; i < 30; i++) begin
      v = (i % 10 == 9) ? 8'hFF : fsp_prot_t'($urandom);
      if (kb(fix(v)) >= kb(p)) p = fix(v);
      prot(v, p);
    end
    $display("test normal mode done");
    smode <= 1'b1;
    repeat (8) @(posedge core_clk);
    prot(8'hFF, 8'hFF);
    prot(8'hF9, 8'hF8);
    prot(8'h07, 8'h07);
    wb(1'b1, `FSP_ADR_MASK, 32'h0);
    wb(1'b1, `FSP_ADR_CMD, {14'h0, FSP_PROG, 1'b0, 15'h7000});
    wb(1'b1, `FSP_ADR_CMD, {14'h0, FSP_PROG, 1'b0, 15'h0100});
    check("refused start", 32'h0, 32'(st));
    wb(1'b0, `FSP_ADR_STAT, 32'h0);
    check("refused status", 32'h9, r);
    check("masked irq", 32'h0, 32'(irq));
    wb(1'b1, `FSP_ADR_STAT, 32'hF);
    sel_use = 4'h6;
    wb(1'b1, `FSP_ADR_PROT, 32'hFF);
    wb(1'b1, `FSP_ADR_CMD, {14'h0, FSP_PROG, 1'b0, 15'h0100});
    check("lane start", 32'h0, 32'(st));
    sel_use = 4'hF;
    wb(1'b0, `FSP_ADR_PROT, 32'h0);
    check("lane prot", 32'h07, r);
    wb(1'b1, `FSP_ADR_MASK, 32'hF);
    wb(1'b1, 8'h10, 32'hFF);
    wb(1'b0, 8'h10, 32'h0);
    check("unmapped", 32'h0, r);
    $display("test special mode done");
    for (int i = 0; i < 40; i++) begin
      p = (i < 4) ? 8'hFF : fix(fsp_prot_t'($urandom));
      prot(p, p);
      cmd(p, fsp_cmd_t'(i % 4), 15'($urandom));
    end
    $display("test commands done");
    prot(8'hFF, 8'hFF);
    do_reset(8'h5B);
    $display("test second reset done");
    final_report();
  end
endmodule
